// File: src/spi_chan_pkg.sv
package spi_chan_pkg;
  // Register indices on the plain register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_MODE = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTL = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_TXD = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_RXD = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_INTF = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_INTE = 3'h5;

  // Mode register fields
  localparam int MASTER_SEL_BIT = 0;
  localparam int LSBF_BIT = 3;
  localparam int CHAR_LEN_LSB = 8;
  localparam int CHAR_LEN_W = 4;
  localparam logic [DATA_W-1:0] MODE_RESET = 16'h0700;
  localparam logic [DATA_W-1:0] MODE_MASK = 16'h0f3f;

  // Control register fields
  localparam int EN_BIT = 0;
  localparam int SRST_BIT = 1;

  // Flag register fields, enable register uses the same positions
  localparam int TBE_BIT = 0;
  localparam int RBF_BIT = 1;
  localparam int TEND_BIT = 2;
  localparam int OVR_BIT = 3;
  localparam int BUSY_BIT = 7;
  localparam int NFLAGS = 4;
  localparam logic [NFLAGS-1:0] FLAGS_RESET = 4'h1;
  localparam logic [NFLAGS-1:0] IRQ_EN_RESET = 4'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
endpackage : spi_chan_pkg

// File: src/spi_sync2.sv
`timescale 1ns/100ps
module spi_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : spi_sync2

// File: src/spi_clk_div.sv
`timescale 1ns/100ps
module spi_clk_div #(
  parameter int HALF = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control and one-cycle tick
  input wire logic run,
  output logic tick
);
  localparam int W = $clog2(HALF + 1);
  localparam logic [W-1:0] LAST = W'(HALF - 1);
  logic [W-1:0] cnt_q;

  assign tick = run && (cnt_q == LAST);

  // Restarts from zero whenever stopped, so the first half period is full length
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else if (!run || tick)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + W'(1);
  end
endmodule : spi_clk_div

// File: src/spi_channel.sv
// Summary of operation
// - Mode bit 1 master, 0 slave
// - Soft reset write 1, reads 1, self-clears
// - Soft reset clears shifter and bit counter
// - Enable bit 0; master clock runs only enabled
// - Transmit write loads buffer; master starts transfer
// - Transmit write accepted whenever buffer empty
// - Bits above length never shifted out
// - Receive bits above length read zero
// - Receive cleared on enable or reset write
// - Busy bit 7: master active, slave selected
// - Overrun, done flags cleared by writing 1
// - Receive full flag cleared by receive read
// - Transmit empty resets 1, cleared by write
// - Four enables gate same-position flags, reset 0
// - Interrupt request only for enabled set flag
// - Character length is field plus one
// - Word into full buffer overwrites, sets overrun
// - Transmit empty set on shifter load
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module spi_channel
  import spi_chan_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [spi_chan_pkg::ADDR_W-1:0] addr,
  input wire logic [spi_chan_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [spi_chan_pkg::DATA_W-1:0] rdata,
  // Interrupt request
  output logic irq_req,
  // Serial clock pin
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n,
  // Serial data and select pins
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  input wire logic slave_select_n
);
  import spi_chan_pkg::*;

  function automatic logic [DATA_W-1:0] len_mask(input logic [CNT_W-1:0] n);
    len_mask = 16'hffff >> (5'd16 - n);
  endfunction : len_mask

  function automatic logic [DATA_W-1:0] len_bit(input logic [CNT_W-1:0] n);
    len_bit = 16'h0001 << (n - 5'd1);
  endfunction : len_bit

  // Registers
  logic [DATA_W-1:0] mode_q;
  logic chan_en_q;
  logic srst_q;
  logic [DATA_W-1:0] tx_buf_q;
  logic [DATA_W-1:0] rx_buf_q;
  logic tx_empty_q;
  logic rx_full_q;
  logic tx_done_q;
  logic overrun_q;
  logic [NFLAGS-1:0] irq_en_q;
  logic [DATA_W-1:0] rdata_q;
  // Shift engine
  logic [DATA_W-1:0] shift_q;
  logic [CNT_W-1:0] cnt_q;
  logic active_q;
  logic sclk_q;
  logic sample_q;
  logic sdo_q;
  logic sclk_prev_q;

  // Pin synchronisers
  logic [2:0] pins_s;
  logic sclk_s;
  logic ss_s;
  logic sdi_s;

  spi_sync2 #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({sclk_i, slave_select_n, serial_in_pin}),
    .sync_out(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign ss_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // Decoding
  wire master = mode_q[MASTER_SEL_BIT];
  wire lsb_first = mode_q[LSBF_BIT];
  wire [CNT_W-1:0] len = {1'b0, mode_q[CHAR_LEN_LSB +: CHAR_LEN_W]} + 5'd1;
  wire [DATA_W-1:0] lmask = len_mask(len);
  wire run = chan_en_q && !srst_q;
  wire wr_mode = wr_stb && (addr == OFS_MODE);
  wire wr_ctl = wr_stb && (addr == OFS_CTL);
  wire wr_txd = wr_stb && (addr == OFS_TXD);
  wire wr_intf = wr_stb && (addr == OFS_INTF);
  wire wr_inte = wr_stb && (addr == OFS_INTE);
  wire rd_rxd = rd_stb && (addr == OFS_RXD);
  wire rx_clear = wr_ctl && (wdata[EN_BIT] || wdata[SRST_BIT]);

  // Master clock runs only while enabled and a word is in flight
  logic tick;
  spi_clk_div #(.HALF(SCLK_HALF_CYC)) u_div (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(run && master && active_q),
    .tick(tick)
  );

  // Edges: master from its own divider, slave from the sampled pin
  wire slave_sel = !master && !ss_s;
  wire rise_ev = run && (master ? (tick && !sclk_q) : (slave_sel && sclk_s && !sclk_prev_q));
  wire fall_ev = run && (master ? (tick && sclk_q) : (slave_sel && !sclk_s && sclk_prev_q));
  wire slave_idle = (cnt_q == '0) && !rise_ev && !fall_ev;
  wire load_ev = run && !tx_empty_q && (master ? !active_q : slave_idle);
  wire word_done = fall_ev && ((cnt_q + 5'd1) == len);
  wire busy = master ? active_q : !ss_s;

  // Next shifter value: MSB first shifts left, LSB first inserts at top of word
  wire [DATA_W-1:0] lbit = len_bit(len);
  wire [DATA_W-1:0] shl = {shift_q[DATA_W-2:0], sample_q};
  wire [DATA_W-1:0] shr = ({1'b0, shift_q[DATA_W-1:1]} & ~lbit) | (sample_q ? lbit : 16'h0000);
  wire [DATA_W-1:0] shift_nx = lsb_first ? shr : shl;
  // Only bits inside the length reach the pin
  wire out_bit = lsb_first ? shift_q[0] : |(shift_q & lbit);

  // Control and mode registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q <= MODE_RESET;
      chan_en_q <= 1'b0;
      srst_q <= 1'b0;
      irq_en_q <= IRQ_EN_RESET;
    end
    else
    begin
      if (wr_mode)
        mode_q <= wdata & MODE_MASK;
      if (wr_ctl)
        chan_en_q <= wdata[EN_BIT];
      srst_q <= wr_ctl && wdata[SRST_BIT];
      if (wr_inte)
        irq_en_q <= wdata[NFLAGS-1:0];
    end
  end

  // Transmit buffer
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_buf_q <= 16'h0000;
    else if (wr_txd)
      tx_buf_q <= wdata;
  end

  // Receive buffer; a clearing write wins over a word landing in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_buf_q <= 16'h0000;
    else if (rx_clear)
      rx_buf_q <= 16'h0000;
    else if (word_done)
      rx_buf_q <= shift_nx & lmask;
  end

  // Flags: hardware set always beats software clear
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_empty_q <= FLAGS_RESET[TBE_BIT];
      rx_full_q <= FLAGS_RESET[RBF_BIT];
      tx_done_q <= FLAGS_RESET[TEND_BIT];
      overrun_q <= FLAGS_RESET[OVR_BIT];
    end
    else
    begin
      if (load_ev)
        tx_empty_q <= 1'b1;
      else if (wr_txd)
        tx_empty_q <= 1'b0;
      if (word_done)
        rx_full_q <= 1'b1;
      else if (rd_rxd)
        rx_full_q <= 1'b0;
      if (word_done && tx_empty_q)
        tx_done_q <= 1'b1;
      else if (wr_intf && wdata[TEND_BIT])
        tx_done_q <= 1'b0;
      if (word_done && rx_full_q)
        overrun_q <= 1'b1;
      else if (wr_intf && wdata[OVR_BIT])
        overrun_q <= 1'b0;
    end
  end

  // Shift engine
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_q <= 16'h0000;
      cnt_q <= '0;
      active_q <= 1'b0;
      sclk_q <= 1'b0;
      sample_q <= 1'b0;
    end
    else if (srst_q)
    begin
      shift_q <= 16'h0000;
      cnt_q <= '0;
      active_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else if (!master && ss_s)
    begin
      // Deselect mid-word drops the partial word
      cnt_q <= '0;
      active_q <= 1'b0;
      sclk_q <= 1'b0;
      // A word written while deselected must still reach the shifter
      if (load_ev)
        shift_q <= tx_buf_q;
    end
    else
    begin
      if (load_ev)
      begin
        shift_q <= tx_buf_q;
        active_q <= master;
      end
      if (rise_ev)
        sample_q <= sdi_s;
      if (master && tick)
        sclk_q <= !sclk_q;
      if (fall_ev)
      begin
        shift_q <= shift_nx;
        cnt_q <= word_done ? '0 : cnt_q + 5'd1;
      end
      if (word_done)
        active_q <= 1'b0;
    end
  end

  // Pin side registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sdo_q <= 1'b0;
      sclk_prev_q <= 1'b1;
    end
    else
    begin
      sdo_q <= out_bit;
      sclk_prev_q <= sclk_s;
    end
  end

  assign serial_out_pin = sdo_q;
  assign sclk_o = sclk_q;
  assign sclk_oe_n = !(master && chan_en_q);

  // Register read, data stands one cycle after the strobe
  wire [NFLAGS-1:0] flags = {overrun_q, tx_done_q, rx_full_q, tx_empty_q};
  wire [DATA_W-1:0] intf_val = {8'h00, busy, 3'h0, flags};
  wire [DATA_W-1:0] read_val =
    (addr == OFS_MODE) ? mode_q :
    (addr == OFS_CTL) ? {14'h0000, srst_q, chan_en_q} :
    (addr == OFS_TXD) ? tx_buf_q :
    (addr == OFS_RXD) ? (rx_buf_q & lmask) :
    (addr == OFS_INTF) ? intf_val :
    (addr == OFS_INTE) ? {12'h000, irq_en_q} :
    16'h0000;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rd_stb ? read_val : 16'h0000;
  end
  assign rdata = rdata_q;

  assign irq_req = |(flags & irq_en_q);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_slave_no_drive:
    assert property (!master |-> sclk_oe_n)
    else $error("serial clock driven in slave mode");
  a_srst_pulse:
    assert property ((wr_ctl && wdata[SRST_BIT]) |=> srst_q ##1 (!srst_q || $past(wr_ctl)))
    else $error("soft reset bit did not self-clear");
  a_srst_clears:
    assert property (srst_q |=> (cnt_q == '0) && (shift_q == 16'h0000) && !active_q)
    else $error("soft reset left engine state");
  a_clock_stops:
    assert property ((master && !chan_en_q) |=> $stable(sclk_q))
    else $error("master clock moved while disabled");
  a_tx_write_clr:
    assert property ((wr_txd && tx_empty_q && !load_ev) |=> !tx_empty_q)
    else $error("transmit write did not clear empty flag");
  a_load_sets_tbe:
    assert property (load_ev |=> tx_empty_q && (shift_q == $past(tx_buf_q)))
    else $error("load did not set empty flag");
  a_rx_masked:
    assert property ((rd_rxd && !wr_mode) |=> (rdata & ~lmask) == 16'h0000)
    else $error("receive bits above length not zero");
  a_rx_cleared:
    assert property (rx_clear |=> rx_buf_q == 16'h0000)
    else $error("receive buffer not cleared");
  a_overrun_set:
    assert property ((word_done && rx_full_q) |=> overrun_q && rx_full_q)
    else $error("overrun not flagged");
  a_w1c_overrun:
    assert property ((wr_intf && wdata[OVR_BIT] && !(word_done && rx_full_q)) |=> !overrun_q)
    else $error("overrun flag not cleared by write one");
  a_rbf_read_clr:
    assert property ((rd_rxd && !word_done) |=> !rx_full_q)
    else $error("receive full not cleared by read");
  a_irq_gated:
    assert property ((irq_en_q == 4'h0) |-> !irq_req)
    else $error("interrupt request without enable");
  a_busy_slave:
    assert property ((!master && $past(!ss_s, 1) && !ss_s) |=> rdata[BUSY_BIT] || !$past(rd_stb && addr == OFS_INTF))
    else $error("busy low while slave selected");

  c_master_word: cover property (master && word_done);
  c_slave_word: cover property (!master && word_done);
  c_overrun: cover property (word_done && rx_full_q);
  c_back_to_back: cover property (master && word_done ##[1:40] load_ev);
endmodule : spi_channel

// File: testbench/spi_partner.sv
`timescale 1ns/100ps
module spi_partner (
  // Lines from the channel
  input wire logic clk_from_dut,
  input wire logic data_from_dut,
  // Lines the partner drives
  output logic data_to_dut,
  output logic clk_to_dut,
  output logic select_n
);
  logic [15:0] reply_q;
  logic [15:0] got_q;

  initial
  begin
    reply_q = 16'h0000;
    got_q = 16'h0000;
    data_to_dut = 1'b0;
    clk_to_dut = 1'b0;
    select_n = 1'b1;
  end

  // Mode 0 either way round: sample on rising clock
  always @(posedge clk_from_dut or posedge clk_to_dut)
  begin
    got_q <= {got_q[14:0], data_from_dut};
  end

  // Change on falling clock; spent bits refill with a changing pattern
  always @(negedge clk_from_dut or negedge clk_to_dut)
  begin
    reply_q <= {reply_q[14:0], ~reply_q[0]};
    data_to_dut <= reply_q[14];
  end

  task automatic load(input logic [15:0] w);
    reply_q = w;
    data_to_dut = w[15];
    got_q = 16'h0000;
  endtask : load

  // Acts as master, 160 ns link clock, clock still outside the frame
  task automatic drive(input int n);
    // Keep pin edges off the sampling edge of the block's clock
    #2;
    select_n = 1'b0;
    #80;
    repeat (n)
    begin
      clk_to_dut = 1'b1;
      #80;
      clk_to_dut = 1'b0;
      #80;
    end
    select_n = 1'b1;
    data_to_dut = ~data_to_dut;
  endtask : drive
endmodule : spi_partner

// File: testbench/spi_channel_tb.sv
`timescale 1ns/100ps
module spi_channel_tb;
  import spi_chan_pkg::*;
  logic ref_clk;
  logic reset_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [DATA_W-1:0] rdata;
  logic irq_req;
  logic sclk_i;
  logic sclk_o;
  logic sclk_oe_n;
  logic serial_out_pin;
  logic serial_in_pin;
  logic slave_select_n;
  logic [DATA_W-1:0] rd_val;
  int err_total;
  int samples_checked;

  spi_channel i_spi_channel (
    .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq_req(irq_req),
    .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
    .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin),
    .slave_select_n(slave_select_n)
  );

  spi_partner i_spi_partner (
    .clk_from_dut(sclk_o), .data_from_dut(serial_out_pin),
    .data_to_dut(serial_in_pin), .clk_to_dut(sclk_i), .select_n(slave_select_n)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    rd_val = rdata;
  endtask : rd

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd(a);
    check(rd_val, exp);
  endtask : rdchk

  // Bounded poll of one flag bit
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    rd(OFS_INTF);
    while (rd_val[b] !== 1'b1 && n < 500)
    begin
      rd(OFS_INTF);
      n++;
    end
    check({15'h0000, rd_val[b]}, 16'h0001);
  endtask : wait_flag

  initial
  begin
    #200000;
    err_total++;
    results();
  end

  initial
  begin
    err_total = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    addr = '0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdchk(OFS_MODE, MODE_RESET);
    rdchk(OFS_CTL, 16'h0000);
    rdchk(OFS_TXD, 16'h0000);
    rdchk(OFS_RXD, 16'h0000);
    rdchk(OFS_INTF, 16'h0001);
    rdchk(OFS_INTE, 16'h0000);
    wr(3'h7, 16'hffff);
    rdchk(3'h7, 16'h0000);
    check({15'h0000, irq_req}, 16'h0000);
    wr(OFS_INTE, 16'h0001);
    #1;
    check({15'h0000, irq_req}, 16'h0001);
    wr(OFS_INTE, 16'h0000);
    // Master, 8-bit words
    i_spi_partner.load(16'h5a00);
    wr(OFS_MODE, 16'h0701);
    wr(OFS_CTL, 16'h0001);
    wr(OFS_TXD, 16'ha5c3);
    rdchk(OFS_INTF, 16'h0081);
    check({15'h0000, sclk_oe_n}, 16'h0000);
    wait_flag(RBF_BIT);
    check(i_spi_partner.got_q, 16'h00c3);
    rdchk(OFS_INTF, 16'h0007);
    rdchk(OFS_RXD, 16'h005a);
    rdchk(OFS_INTF, 16'h0005);
    // Second word written while the first still shifts, nothing read
    i_spi_partner.load(16'h3cc3);
    wr(OFS_TXD, 16'h0011);
    wr(OFS_TXD, 16'h0022);
    wait_flag(OVR_BIT);
    check(i_spi_partner.got_q, 16'h1122);
    rdchk(OFS_INTF, 16'h000f);
    wr(OFS_INTE, 16'h0008);
    #1;
    check({15'h0000, irq_req}, 16'h0001);
    wr(OFS_INTF, 16'h0000);
    rdchk(OFS_INTF, 16'h000f);
    wr(OFS_INTF, 16'h0008);
    rdchk(OFS_INTF, 16'h0007);
    check({15'h0000, irq_req}, 16'h0000);
    wr(OFS_INTF, 16'h0004);
    rdchk(OFS_INTF, 16'h0003);
    wr(OFS_CTL, 16'h0003);
    rdchk(OFS_CTL, 16'h0001);
    rdchk(OFS_RXD, 16'h0000);
    // Slave, 16-bit words
    wr(OFS_CTL, 16'h0000);
    wr(OFS_MODE, 16'h0f00);
    wr(OFS_CTL, 16'h0003);
    wr(OFS_TXD, 16'h1234);
    i_spi_partner.load(16'hbeef);
    fork
      i_spi_partner.drive(16);
      begin
        #400;
        rd(OFS_INTF);
        check({15'h0000, rd_val[BUSY_BIT]}, 16'h0001);
      end
    join
    wait_flag(RBF_BIT);
    rdchk(OFS_RXD, 16'hbeef);
    check(i_spi_partner.got_q, 16'h1234);
    rdchk(OFS_INTF, 16'h0005);
    // Master, LSB first, upper transmit bits dropped
    wr(OFS_CTL, 16'h0000);
    wr(OFS_MODE, 16'h0709);
    wr(OFS_CTL, 16'h0003);
    i_spi_partner.load(16'hc000);
    wr(OFS_TXD, 16'hff03);
    wait_flag(RBF_BIT);
    check(i_spi_partner.got_q, 16'h00c0);
    rdchk(OFS_RXD, 16'h0003);
    results();
  end
endmodule : spi_channel_tb
